// >>> hw/msp_pkg.sv
// Constants, encodings and register map of the multi-step sequencer
package msp_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_SETPOINT = 12'h000;
  localparam logic [11:0] OFS_STEP_CFG = 12'h040;
  localparam logic [11:0] OFS_CTRL     = 12'h080;
  localparam logic [11:0] OFS_STATUS   = 12'h084;
  localparam logic [11:0] OFS_RESUME   = 12'h088;

  // Control register field positions
  localparam int CTRL_END_LSB  = 0;
  localparam int CTRL_PWR_MEM  = 4;
  localparam int CTRL_STOP_MEM = 5;
  localparam int CTRL_UNIT     = 8;
  localparam int CTRL_SRC_LSB  = 12;
  localparam int CTRL_APP_LSB  = 16;
  localparam int CTRL_SEQ_EN   = 20;
  // Step config and status field positions
  localparam int CFG_ACC_LSB   = 16;
  localparam int STAT_RUN      = 4;
  localparam int STAT_HOLD     = 5;
  localparam int STAT_SAVED    = 6;
  localparam int WORD_HI_LSB   = 16;

  // Values after reset
  localparam logic [15:0] SETPOINT_RST = 16'h0000;
  localparam logic [15:0] DURATION_RST = 16'h0000;
  localparam logic [1:0]  ACC_SEL_RST  = 2'h0;
  localparam logic [1:0]  END_MODE_RST = 2'h0;
  localparam logic [1:0]  RETAIN_RST   = 2'h0;
  localparam logic        UNIT_RST     = 1'b0;
  localparam logic [2:0]  SRC_RST      = 3'h0;

  // Relative full scale: 100.0 % in tenths
  localparam logic [15:0] REL_LIMIT    = 16'h03E8;
  localparam logic [3:0]  LAST_STEP    = 4'hF;

  // End-of-pass behaviours
  localparam logic [1:0] END_STOP  = 2'h0;
  localparam logic [1:0] END_HOLD  = 2'h1;
  localparam logic [1:0] END_CYCLE = 2'h2;
  // Use of the step value
  localparam logic [1:0] APP_FREQ  = 2'h0;
  localparam logic [1:0] APP_VOLT  = 2'h1;
  localparam logic [1:0] APP_PID   = 2'h2;
  // Step zero sources
  localparam logic [2:0] SRC_TABLE  = 3'h0;
  localparam logic [2:0] SRC_AI_ONE = 3'h1;
  localparam logic [2:0] SRC_AI_TWO = 3'h2;
  localparam logic [2:0] SRC_POT    = 3'h3;
  localparam logic [2:0] SRC_PULSE  = 3'h4;
  localparam logic [2:0] SRC_PID    = 3'h5;
  localparam logic [2:0] SRC_PRESET = 3'h6;

  // Time base: one tick is a tenth of the selected unit
  localparam longint CLK_HZ        = 64'h0EE6_B280;
  localparam longint MS_PER_S      = 64'h3E8;
  localparam longint TENTH_SEC_MS  = 64'h64;
  localparam longint TENTH_HOUR_MS = 64'h5_7E40;
  localparam longint TICK_SEC_CYC  = TENTH_SEC_MS * CLK_HZ / MS_PER_S;
  localparam longint TICK_HOUR_CYC = TENTH_HOUR_MS * CLK_HZ / MS_PER_S;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_HOLD} msp_seq_t;

endpackage

// >>> hw/msp_sequencer.sv
// Sixteen-step setpoint table and timed sequencer with APB registers
`timescale 1ns/1ps
module msp_sequencer #(
  parameter logic [39:0] TICK_SEC_CYC  = 40'(msp_pkg::TICK_SEC_CYC),
  parameter logic [39:0] TICK_HOUR_CYC = 40'(msp_pkg::TICK_HOUR_CYC)
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Drive commands and step selection
  input  wire logic        run_cmd,
  input  wire logic        stop_cmd,
  input  wire logic [3:0]  step_select,
  // Alternative step zero sources, signed tenths of a percent
  input  wire logic [15:0] analog_input_one,
  input  wire logic [15:0] analog_input_two,
  input  wire logic [15:0] panel_pot_value,
  input  wire logic [15:0] pulse_input_value,
  input  wire logic [15:0] pid_output_value,
  input  wire logic [15:0] digital_preset_frequency,
  // Scaling references
  input  wire logic [15:0] maximum_frequency_limit,
  input  wire logic [15:0] motor_rated_voltage,
  // Setpoint outputs
  output logic      [15:0] setpoint_out,
  output logic             reverse_out,
  output logic      [1:0]  ramp_set_out,
  output logic      [3:0]  active_step_out,
  output logic             drive_run_out,
  output logic             pass_done_out
);

  typedef struct packed {
    logic [15:0][15:0]  sp;
    logic [15:0][15:0]  dur;
    logic [15:0][1:0]   acc;
    logic [1:0]         end_mode;
    logic               pwr_mem;
    logic               stop_mem;
    logic               unit;
    logic [2:0]         src;
    logic [1:0]         app;
    logic               seq_en;
    msp_pkg::msp_seq_t  fsm;
    logic [3:0]         step;
    logic [15:0]        elapsed;
    logic [39:0]        tick_cnt;
    logic [3:0]         saved_step;
    logic [15:0]        saved_elapsed;
    logic               saved_valid;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
    logic [15:0]        setpoint;
    logic               reverse;
    logic [1:0]         acc_out;
    logic [3:0]         step_out;
    logic               run;
    logic               pass_done;
  } msp_state_t;

  msp_state_t  st;
  msp_state_t  next_st;
  logic        wr;
  logic [3:0]  active;
  logic [15:0] value;
  logic [39:0] tick_len;
  logic [1:0]  end_eff;
  logic        step_over;

  // Limit a signed relative value to the full-scale span
  function automatic logic [15:0] clamp_rel(input logic [15:0] v);
    if ($signed(v) > $signed(msp_pkg::REL_LIMIT)) begin
      return msp_pkg::REL_LIMIT;
    end else if ($signed(v) < -$signed(msp_pkg::REL_LIMIT)) begin
      return 16'(-msp_pkg::REL_LIMIT);
    end
    return v;
  endfunction

  // Magnitude of a relative value against a reference
  function automatic logic [15:0] scale_rel(input logic [15:0] v, input logic [15:0] r);
    logic [15:0] mag;
    logic [31:0] prod;
    mag  = v[15] ? 16'(-v) : v;
    prod = 32'(mag) * 32'(r);
    return 16'(prod / 32'(msp_pkg::REL_LIMIT));
  endfunction

  // Word-aligned address inside the map
  function automatic logic addr_mapped(input logic [11:0] a);
    return (a[1:0] == 2'h0) && (a <= msp_pkg::OFS_RESUME);
  endfunction

  // Read mux; unmapped words read as zero
  function automatic logic [31:0] read_word(input msp_state_t s, input logic [11:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a < msp_pkg::OFS_STEP_CFG) begin
      d[15:0] = s.sp[a[5:2]];
    end else if (a < msp_pkg::OFS_CTRL) begin
      d[15:0] = s.dur[a[5:2]];
      d[msp_pkg::CFG_ACC_LSB +: 2] = s.acc[a[5:2]];
    end else if (a == msp_pkg::OFS_CTRL) begin
      d[msp_pkg::CTRL_END_LSB +: 2] = s.end_mode;
      d[msp_pkg::CTRL_PWR_MEM]      = s.pwr_mem;
      d[msp_pkg::CTRL_STOP_MEM]     = s.stop_mem;
      d[msp_pkg::CTRL_UNIT]         = s.unit;
      d[msp_pkg::CTRL_SRC_LSB +: 3] = s.src;
      d[msp_pkg::CTRL_APP_LSB +: 2] = s.app;
      d[msp_pkg::CTRL_SEQ_EN]       = s.seq_en;
    end else if (a == msp_pkg::OFS_STATUS) begin
      d[3:0]                 = s.step;
      d[msp_pkg::STAT_RUN]   = (s.fsm != msp_pkg::SEQ_IDLE);
      d[msp_pkg::STAT_HOLD]  = (s.fsm == msp_pkg::SEQ_HOLD);
      d[msp_pkg::STAT_SAVED] = s.saved_valid;
      d[msp_pkg::WORD_HI_LSB +: 16] = s.elapsed;
    end else if (a == msp_pkg::OFS_RESUME) begin
      d[3:0] = s.saved_step;
      d[msp_pkg::WORD_HI_LSB +: 16] = s.saved_elapsed;
    end
    return d;
  endfunction

  // Write strobe lands on the completing edge only
  assign wr = psel && penable && pwrite && st.pready;

  // Next-state logic: bus, sequencer, output stage
  always_comb begin
    next_st   = st;
    active    = 4'h0;
    value     = 16'h0000;
    end_eff   = msp_pkg::END_CYCLE;
    step_over = 1'b0;
    next_st.pass_done = 1'b0;

    // One wait state; read data and error prepared for the completing edge
    next_st.pready = psel && penable && !st.pready;
    if (psel && penable && !st.pready) begin
      next_st.prdata  = pwrite ? 32'h0000_0000 : read_word(st, paddr);
      next_st.pslverr = !addr_mapped(paddr);
    end

    if (wr && addr_mapped(paddr)) begin
      if (paddr < msp_pkg::OFS_STEP_CFG) begin
        next_st.sp[paddr[5:2]] = clamp_rel(pwdata[15:0]);
      end else if (paddr < msp_pkg::OFS_CTRL) begin
        next_st.dur[paddr[5:2]] = pwdata[15:0];
        next_st.acc[paddr[5:2]] = pwdata[msp_pkg::CFG_ACC_LSB +: 2];
      end else if (paddr == msp_pkg::OFS_CTRL) begin
        next_st.end_mode = pwdata[msp_pkg::CTRL_END_LSB +: 2];
        next_st.pwr_mem  = pwdata[msp_pkg::CTRL_PWR_MEM];
        next_st.stop_mem = pwdata[msp_pkg::CTRL_STOP_MEM];
        next_st.unit     = pwdata[msp_pkg::CTRL_UNIT];
        next_st.src      = pwdata[msp_pkg::CTRL_SRC_LSB +: 3];
        next_st.app      = pwdata[msp_pkg::CTRL_APP_LSB +: 2];
        next_st.seq_en   = pwdata[msp_pkg::CTRL_SEQ_EN];
      end else if (paddr == msp_pkg::OFS_RESUME && st.pwr_mem) begin
        // Stage restored from non-volatile store after power-up
        next_st.saved_step    = pwdata[3:0];
        next_st.saved_elapsed = pwdata[msp_pkg::WORD_HI_LSB +: 16];
        next_st.saved_valid   = 1'b1;
      end
    end

    // Tick length follows the unit; hours need a 37-bit count
    tick_len = st.unit ? TICK_HOUR_CYC : TICK_SEC_CYC;
    // End-of-pass behaviour; voltage and PID use simply cycle
    end_eff  = (st.app == msp_pkg::APP_FREQ) ? st.end_mode : msp_pkg::END_CYCLE;

    unique case (st.fsm)
      msp_pkg::SEQ_IDLE: begin
        if (run_cmd && !stop_cmd) begin
          next_st.fsm         = msp_pkg::SEQ_RUN;
          next_st.step        = st.saved_valid ? st.saved_step : 4'h0;
          next_st.elapsed     = st.saved_valid ? st.saved_elapsed : 16'h0000;
          // A record restored in this very cycle is kept for the next run
          if (!(wr && paddr == msp_pkg::OFS_RESUME && st.pwr_mem)) begin
            next_st.saved_valid = 1'b0;
          end
          next_st.tick_cnt    = 40'h00_0000_0000;
        end
      end
      msp_pkg::SEQ_RUN: begin
        if (stop_cmd) begin
          next_st.fsm           = msp_pkg::SEQ_IDLE;
          next_st.saved_step    = st.step;
          next_st.saved_elapsed = st.elapsed;
          next_st.saved_valid   = st.stop_mem;
        end else if (st.seq_en) begin
          // Tenth-unit time base, running only in this state
          if (st.tick_cnt >= tick_len - 40'h00_0000_0001) begin
            next_st.tick_cnt = 40'h00_0000_0000;
            next_st.elapsed  = st.elapsed + 16'h0001;
            step_over = (st.elapsed + 16'h0001 >= st.dur[st.step]);
          end else begin
            next_st.tick_cnt = st.tick_cnt + 40'h00_0000_0001;
          end
          // Zero duration passes the step on at once
          if (st.dur[st.step] == 16'h0000) begin
            step_over = 1'b1;
          end
          if (step_over) begin
            next_st.elapsed  = 16'h0000;
            next_st.tick_cnt = 40'h00_0000_0000;
            if (st.step != msp_pkg::LAST_STEP) begin
              next_st.step = st.step + 4'h1;
            end else begin
              next_st.pass_done = 1'b1;
              case (end_eff)
                msp_pkg::END_HOLD: begin
                  next_st.fsm = msp_pkg::SEQ_HOLD;
                end
                msp_pkg::END_CYCLE: begin
                  next_st.step = 4'h0;
                end
                default: begin
                  // Code 3 is not defined; it stops like code 0
                  next_st.fsm  = msp_pkg::SEQ_IDLE;
                  next_st.step = 4'h0;
                end
              endcase
            end
          end
        end
      end
      msp_pkg::SEQ_HOLD: begin
        // Last step keeps frequency and direction until a stop
        if (stop_cmd) begin
          next_st.fsm           = msp_pkg::SEQ_IDLE;
          next_st.saved_step    = st.step;
          next_st.saved_elapsed = st.elapsed;
          next_st.saved_valid   = st.stop_mem;
        end
      end
      default: begin
        next_st.fsm = msp_pkg::SEQ_IDLE;
      end
    endcase

    // Output stage, from the values that the edge will hold
    active = next_st.seq_en ? next_st.step : step_select;
    value  = next_st.sp[active];
    if (active == 4'h0) begin
      unique case (next_st.src)
        msp_pkg::SRC_AI_ONE: value = clamp_rel(analog_input_one);
        msp_pkg::SRC_AI_TWO: value = clamp_rel(analog_input_two);
        msp_pkg::SRC_POT:    value = clamp_rel(panel_pot_value);
        msp_pkg::SRC_PULSE:  value = clamp_rel(pulse_input_value);
        msp_pkg::SRC_PID:    value = clamp_rel(pid_output_value);
        msp_pkg::SRC_PRESET: value = clamp_rel(digital_preset_frequency);
        default:             value = next_st.sp[0];
      endcase
    end
    unique case (next_st.app)
      msp_pkg::APP_FREQ: next_st.setpoint = scale_rel(value, maximum_frequency_limit);
      msp_pkg::APP_VOLT: next_st.setpoint = scale_rel(value, motor_rated_voltage);
      default:           next_st.setpoint = value;
    endcase
    next_st.reverse  = (next_st.app == msp_pkg::APP_FREQ) && value[15];
    next_st.acc_out  = next_st.acc[active];
    next_st.step_out = active;
    next_st.run      = (next_st.fsm != msp_pkg::SEQ_IDLE);
  end

  // State register; saved stage is lost at reset unless restored
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st          <= '0;
      st.sp       <= {16{msp_pkg::SETPOINT_RST}};
      st.dur      <= {16{msp_pkg::DURATION_RST}};
      st.acc      <= {16{msp_pkg::ACC_SEL_RST}};
      st.end_mode <= msp_pkg::END_MODE_RST;
      st.pwr_mem  <= msp_pkg::RETAIN_RST[0];
      st.stop_mem <= msp_pkg::RETAIN_RST[1];
      st.unit     <= msp_pkg::UNIT_RST;
      st.src      <= msp_pkg::SRC_RST;
      st.fsm      <= msp_pkg::SEQ_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Ports straight from the state register
  assign prdata          = st.prdata;
  assign pready          = st.pready;
  assign pslverr         = st.pslverr;
  assign setpoint_out    = st.setpoint;
  assign reverse_out     = st.reverse;
  assign ramp_set_out    = st.acc_out;
  assign active_step_out = st.step_out;
  assign drive_run_out   = st.run;
  assign pass_done_out   = st.pass_done;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // Every stored step stays in range
  for (genvar g = 0; g < 16; g++) begin : g_range
    step_range_a: assert property (
      $signed(st.sp[g]) <= $signed(msp_pkg::REL_LIMIT) &&
      $signed(st.sp[g]) >= -$signed(msp_pkg::REL_LIMIT))
      else $error("step setpoint out of range");
  end

  manual_select_a: assert property (
    $past(resetn) && !st.seq_en |-> st.step_out == $past(step_select))
    else $error("manual step not taken from select inputs");

  mode0_stop_a: assert property (
    st.pass_done && st.app == msp_pkg::APP_FREQ && st.end_mode == msp_pkg::END_STOP
    |-> !st.run ##1 (!st.run || $past(run_cmd)))
    else $error("mode 0 did not stop after pass");

  mode1_hold_a: assert property (
    st.pass_done && st.app == msp_pkg::APP_FREQ && st.end_mode == msp_pkg::END_HOLD
    && st.seq_en |-> st.run && st.step_out == msp_pkg::LAST_STEP)
    else $error("mode 1 did not hold last step");

  mode2_cycle_a: assert property (
    st.pass_done && st.app == msp_pkg::APP_FREQ && st.end_mode == msp_pkg::END_CYCLE
    && st.seq_en |-> st.run && st.step_out == 4'h0)
    else $error("mode 2 did not restart pass");

  non_freq_end_a: assert property (
    st.pass_done && st.app != msp_pkg::APP_FREQ |-> st.run && st.step == 4'h0)
    else $error("end mode applied outside frequency use");

  stop_memory_a: assert property (
    st.fsm == msp_pkg::SEQ_RUN && stop_cmd && st.stop_mem && !wr
    |=> st.saved_valid && st.saved_step == $past(st.step) && !st.run)
    else $error("stop retention lost the stage");

  step_order_a: assert property (
    st.fsm == msp_pkg::SEQ_RUN && $past(st.fsm) == msp_pkg::SEQ_RUN && $changed(st.step)
    |-> st.step == $past(st.step) + 4'h1 || st.step == 4'h0)
    else $error("steps not taken in ascending order");

  idle_time_a: assert property (
    st.fsm != msp_pkg::SEQ_RUN && !run_cmd |=> $stable(st.elapsed))
    else $error("step time advanced while not running");

endmodule

// >>> tb/msp_drive_model.sv
// Behavioural consumer of the sequencer's drive outputs
`timescale 1ns/1ps
module msp_drive_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Drive status from the block
  input  wire logic        drive_run_out,
  input  wire logic        pass_done_out,
  // Observations for the bench
  output logic      [7:0]  pass_count,
  output logic      [15:0] run_cycles
);
  // Count passes; a level instead of a pulse would show as extra passes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pass_count <= 8'h00;
      run_cycles <= 16'h0000;
    end else begin
      if (pass_done_out) pass_count <= pass_count + 8'h01;
      if (drive_run_out) run_cycles <= run_cycles + 16'h0001;
    end
  end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the multi-step sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin num_errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
  // Stimulus
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        run_cmd = 1'b0;
  logic        stop_cmd = 1'b0;
  logic [3:0]  step_select = 4'h0;
  logic [15:0] src [6] = '{16'h0011, 16'h0022, 16'h0033, 16'h0044, 16'h0055, 16'h0066};
  logic [15:0] fmax = 16'h07D0;
  logic [15:0] vrat = 16'h0190;
  // Observed values
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic        pready, pslverr, err, reverse_out, drive_run_out, pass_done_out;
  logic [15:0] setpoint_out, run_cycles;
  logic [1:0]  ramp_set_out;
  logic [3:0]  active_step_out;
  logic [7:0]  pass_count;
  int          num_errors = 0;
  int          check_count = 0;
  int          cyc = 0;

  // Short ticks keep step timing within a few cycles
  msp_sequencer #(.TICK_SEC_CYC(40'h4), .TICK_HOUR_CYC(40'h8)) DUT (
    .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .run_cmd(run_cmd), .stop_cmd(stop_cmd), .step_select(step_select),
    .analog_input_one(src[0]), .analog_input_two(src[1]), .panel_pot_value(src[2]),
    .pulse_input_value(src[3]), .pid_output_value(src[4]),
    .digital_preset_frequency(src[5]), .maximum_frequency_limit(fmax),
    .motor_rated_voltage(vrat), .setpoint_out(setpoint_out), .reverse_out(reverse_out),
    .ramp_set_out(ramp_set_out), .active_step_out(active_step_out),
    .drive_run_out(drive_run_out), .pass_done_out(pass_done_out));
  msp_drive_model PM (.sys_clk(sys_clk), .resetn(resetn), .drive_run_out(drive_run_out),
    .pass_done_out(pass_done_out), .pass_count(pass_count), .run_cycles(run_cycles));

  // Clock and hang guard
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  // Report and stop
  task give_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One APB transfer; request held until the edge that samples pready high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Reads right after the edge see what that edge sampled; a hang ends at the timeout
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // One-cycle run (0) or stop (1) command
  task go(input logic s);
    @(posedge sys_clk);
    if (s) stop_cmd <= 1'b1;
    else run_cmd <= 1'b1;
    @(posedge sys_clk);
    run_cmd <= 1'b0;
    stop_cmd <= 1'b0;
  endtask

  // Reset contents and a refused access
  task t_reset();
    apb(1'b0, msp_pkg::OFS_CTRL, 32'h0);
    `CHK("ctrl", 32'h0000_0000, rdat)
    apb(1'b0, 12'h00C, 32'h0);
    `CHK("step3 value", 32'h0000_0000, rdat)
    apb(1'b0, 12'h04C, 32'h0);
    `CHK("step3 cfg", 32'h0000_0000, rdat)
    apb(1'b0, 12'h08C, 32'h0);
    `CHK("unmapped", 1'b1, err)
  endtask

  // Clamp, manual select, scaling per use, direction, ramp, step zero sources
  task t_manual();
    wr(12'h008, 32'h0000_07D0);
    apb(1'b0, 12'h008, 32'h0);
    `CHK("clamp hi", 32'h0000_03E8, rdat)
    wr(12'h014, 32'h0000_F830);
    wr(12'h054, 32'h0002_0000);
    apb(1'b0, 12'h014, 32'h0);
    `CHK("clamp lo", 32'h0000_FC18, rdat)
    step_select <= 4'h5;
    repeat (3) @(negedge sys_clk);
    `CHK("freq sp", 16'h07D0, setpoint_out)
    `CHK("reverse", 1'b1, reverse_out)
    `CHK("ramp set", 2'h2, ramp_set_out)
    `CHK("manual step", 4'h5, active_step_out)
    wr(msp_pkg::OFS_CTRL, 32'h0001_0000);
    repeat (2) @(negedge sys_clk);
    `CHK("volt sp", 16'h0190, setpoint_out)
    `CHK("volt dir", 1'b0, reverse_out)
    wr(msp_pkg::OFS_CTRL, 32'h0002_0000);
    repeat (2) @(negedge sys_clk);
    `CHK("pid sp", 16'hFC18, setpoint_out)
    step_select <= 4'h0;
    for (int k = 1; k < 7; k++) begin
      wr(msp_pkg::OFS_CTRL, 32'h0002_0000 | (32'(k) << 12));
      repeat (2) @(negedge sys_clk);
      `CHK("step0 source", src[k-1], setpoint_out)
    end
    wr(msp_pkg::OFS_CTRL, 32'h0002_0000);
    repeat (2) @(negedge sys_clk);
    `CHK("step0 table", 16'h0000, setpoint_out)
  endtask

  // Zero-duration pass: one cycle per step, then the end behaviour
  task t_pass(input logic [31:0] c, input logic er, input logic [3:0] es, input logic [7:0] np);
    logic [7:0] pc;
    logic [15:0] rc;
    wr(msp_pkg::OFS_CTRL, c);
    pc = pass_count;
    rc = run_cycles;
    go(1'b0);
    for (int i = 0; i < 16; i++) begin
      @(negedge sys_clk);
      `CHK("seq step", 4'(i), active_step_out)
    end
    @(negedge sys_clk);
    `CHK("pass pulse", 1'b1, pass_done_out)
    `CHK("run after", er, drive_run_out)
    `CHK("step after", es, active_step_out)
    if (es == 4'hF) `CHK("last dir", 1'b1, reverse_out)
    repeat (17) @(negedge sys_clk);
    `CHK("passes", np, pass_count - pc)
    // Mode 0 in frequency use runs one cycle per step; the others keep running to here
    `CHK("run cycles", er ? 16'h0021 : 16'h0010, run_cycles - rc)
    go(1'b1);
    @(negedge sys_clk);
    `CHK("stopped", 1'b0, drive_run_out)
  endtask

  // Step zero lasts two tenths of the selected unit
  task t_time(input logic [31:0] c, input int t);
    int n;
    wr(msp_pkg::OFS_CTRL, c);
    wr(msp_pkg::OFS_STEP_CFG, 32'h0000_0002);
    go(1'b0);
    n = 0;
    @(negedge sys_clk);
    while (active_step_out === 4'h0 && drive_run_out === 1'b1 && n < 100) begin
      n++;
      @(negedge sys_clk);
    end
    `CHK("step0 time", 1'b1, n >= 2 * t - 1 && n <= 2 * t + 1)
    go(1'b1);
    wr(msp_pkg::OFS_STEP_CFG, 32'h0000_0000);
  endtask

  // Resume stage after stop or after a restored power-loss record
  task t_ret(input logic [31:0] c, input logic rw, input logic [3:0] es);
    int n;
    wr(msp_pkg::OFS_CTRL, c);
    if (rw) begin
      wr(msp_pkg::OFS_RESUME, 32'h0000_0007);
    end else begin
      go(1'b0);
      n = 0;
      @(negedge sys_clk);
      while (active_step_out !== 4'h3 && n < 200) begin
        @(negedge sys_clk);
        n++;
      end
      go(1'b1);
    end
    // Saved flag follows the retention digit in force; machine idle
    apb(1'b0, msp_pkg::OFS_STATUS, 32'h0);
    `CHK("status flags", {c[msp_pkg::CTRL_STOP_MEM] | (rw & c[msp_pkg::CTRL_PWR_MEM]), 2'h0}, rdat[6:4])
    if (c[msp_pkg::CTRL_STOP_MEM] | (rw & c[msp_pkg::CTRL_PWR_MEM])) begin
      apb(1'b0, msp_pkg::OFS_RESUME, 32'h0);
      `CHK("saved step", es, rdat[3:0])
    end
    go(1'b0);
    @(negedge sys_clk);
    `CHK("resume step", es, active_step_out)
    go(1'b1);
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_manual();
    wr(12'h03C, 32'h0000_FC18);
    t_pass(32'h0010_0000, 1'b0, 4'h0, 8'h01);
    t_pass(32'h0010_0001, 1'b1, 4'hF, 8'h01);
    t_pass(32'h0010_0002, 1'b1, 4'h0, 8'h02);
    t_pass(32'h0011_0000, 1'b1, 4'h0, 8'h02);
    t_time(32'h0010_0000, 4);
    t_time(32'h0010_0100, 8);
    for (int i = 0; i < 16; i++) wr(msp_pkg::OFS_STEP_CFG + 12'(4 * i), 32'h0000_0001);
    t_ret(32'h0010_0020, 1'b0, 4'h3);
    t_ret(32'h0010_0000, 1'b0, 4'h0);
    t_ret(32'h0010_0010, 1'b1, 4'h7);
    t_ret(32'h0010_0000, 1'b1, 4'h0);
    give_verdict();
  end
endmodule
